// ### rtl/acr_cal_regs.v
// calibration control and status registers with the calibration sequencer
//
// Function
// - while background calibration runs, only the continue bit and the pattern register accept writes.
// - continue bit 1 starts background calibration, 0 pauses or stops it.
// - background control bit 0 selects background calibration mode.
// - clearing the mode bit may abandon calibration in an incomplete state.
// - pattern register bit 2 enables test pattern, bit 1 over-range; reset 0.
// - with scan enabled, each vector port read returns the next stored value.
// - with scan enabled, each vector port write loads the next stored value.
// - calibration runs on after continue clears; software polls stopped status.
// - status bit 1 reads 0 while calibrating, 1 when finished or stopped.
// - status bit 0 reports first calibration sequence done.
// - timing register bit 0 enables automatic timing optimisation.
// - with automatic timing on, foreground trigger also runs timing calibration.
// - foreground trigger starts foreground calibration, resets sequencer, self-clears.
// - configuration 0 bit 4 is the scan enable for the vector port.
`timescale 1ns/1ps
`default_nettype none
`include "acr_defines.vh"

module acr_cal_regs (
   // clock and reset
   input wire core_clk_in,
   input wire reset_in,
   // register access port from the serial interface
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [`ACR_ADDR_W-1:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   output reg [7:0] reg_rdata_out,
   output reg reg_rvalid_out,
   // converter controls
   output reg test_pattern_enable_out,
   output reg overrange_enable_out,
   // calibration status
   output reg cal_running_out,
   output reg first_cal_done_out
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_FG = 3'h1;
   localparam [2:0] ST_TIMING = 3'h2;
   localparam [2:0] ST_BG = 3'h3;

   // register state
   reg [7:0] cfg0_q;
   reg fg_trigger_q;
   reg [7:0] back_ctrl_q;
   reg [7:0] timing_q;
   reg [`ACR_VEC_IDX_W-1:0] scan_ptr_q;
   reg scan_en_prev_q;

   // sequencer state
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [`ACR_VEC_IDX_W-1:0] step_idx_q;
   reg [`ACR_VEC_IDX_W-1:0] step_idx_d;
   reg [7:0] tick_q;
   reg [7:0] tick_d;
   reg trim_d;
   reg done_d;

   wire [7:0] vec_rd_data;
   wire scan_en;
   wire bck_mode;
   wire cont;
   wire bg_busy;
   wire wr_cfg0;
   wire wr_back;
   wire wr_pat;
   wire wr_vec;
   wire wr_timing;
   wire rd_vec;
   wire vec_load;
   wire step_end;
   wire [7:0] pat_rst;

   assign scan_en = cfg0_q[`ACR_CFG0_SCAN_EN];
   assign bck_mode = back_ctrl_q[`ACR_BACK_MODE_SELECT];
   assign cont = back_ctrl_q[`ACR_BACK_CONTINUE];
   // background pass in progress, including the drain of the current step
   assign bg_busy = (state_q == ST_BG);

   assign wr_cfg0 = reg_wr_in && (reg_addr_in == `ACR_OFS_CAL_CFG0);
   assign wr_back = reg_wr_in && (reg_addr_in == `ACR_OFS_BACK_CTRL);
   assign wr_pat = reg_wr_in && (reg_addr_in == `ACR_OFS_PAT_OVR);
   assign wr_vec = reg_wr_in && (reg_addr_in == `ACR_OFS_VECTOR);
   assign wr_timing = reg_wr_in && (reg_addr_in == `ACR_OFS_TIMING);
   assign rd_vec = reg_rd_in && (reg_addr_in == `ACR_OFS_VECTOR);

   // scan writes go nowhere while background calibration owns the store
   assign vec_load = wr_vec && scan_en && !bg_busy;

   assign step_end = (tick_q == (`ACR_STEP_CYCLES - 8'h01));
   // reset levels come from the shared header rather than being repeated here
   assign pat_rst = `ACR_RST_PAT_OVR;

   // configuration 0: trigger bit is a one-cycle pulse, never stored
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         cfg0_q <= `ACR_RST_CAL_CFG0;
         fg_trigger_q <= 1'b0;
      end else begin
         fg_trigger_q <= 1'b0;
         if (wr_cfg0 && !bg_busy) begin
            cfg0_q <= reg_wdata_in & ~(8'h01 << `ACR_CFG0_FG_TRIGGER);
            fg_trigger_q <= reg_wdata_in[`ACR_CFG0_FG_TRIGGER];
         end
      end
   end

   // background control: only the continue bit moves while a pass runs
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         back_ctrl_q <= `ACR_RST_BACK_CTRL;
      end else if (wr_back) begin
         if (bg_busy) begin
            back_ctrl_q[`ACR_BACK_CONTINUE] <= reg_wdata_in[`ACR_BACK_CONTINUE];
         end else begin
            back_ctrl_q <= reg_wdata_in;
         end
      end
   end

   // pattern and over-range enables are not calibration state, so never locked
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         test_pattern_enable_out <= pat_rst[`ACR_PAT_TEST_PATTERN];
         overrange_enable_out <= pat_rst[`ACR_PAT_OVERRANGE];
      end else if (wr_pat) begin
         test_pattern_enable_out <= reg_wdata_in[`ACR_PAT_TEST_PATTERN];
         overrange_enable_out <= reg_wdata_in[`ACR_PAT_OVERRANGE];
      end
   end

   // timing calibration register
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         timing_q <= `ACR_RST_TIMING;
      end else if (wr_timing && !bg_busy) begin
         timing_q <= reg_wdata_in;
      end
   end

   // scan pointer walks the store on every port read and accepted port write while scan is enabled
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         scan_ptr_q <= {`ACR_VEC_IDX_W{1'b0}};
         scan_en_prev_q <= 1'b0;
      end else begin
         scan_en_prev_q <= scan_en;
         if (scan_en && !scan_en_prev_q) begin
            scan_ptr_q <= {`ACR_VEC_IDX_W{1'b0}};
         end else if (scan_en && (rd_vec || vec_load)) begin
            scan_ptr_q <= scan_ptr_q + 1'b1;
         end
      end
   end

   // sequencer next state
   always @* begin
      state_d = state_q;
      step_idx_d = step_idx_q;
      tick_d = tick_q + 8'h01;
      trim_d = 1'b0;
      done_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            tick_d = 8'h00;
            step_idx_d = {`ACR_VEC_IDX_W{1'b0}};
            if (bck_mode && cont) begin
               state_d = ST_BG;
            end
         end
         ST_FG: begin
            if (step_end) begin
               tick_d = 8'h00;
               trim_d = 1'b1;
               step_idx_d = step_idx_q + 1'b1;
               if (step_idx_q == `ACR_VEC_LAST) begin
                  if (timing_q[`ACR_TIMING_AUTO]) begin
                     state_d = ST_TIMING;
                  end else begin
                     state_d = ST_IDLE;
                     done_d = 1'b1;
                  end
               end
            end
         end
         ST_TIMING: begin
            if (tick_q == (`ACR_TIMING_CYCLES - 8'h01)) begin
               tick_d = 8'h00;
               state_d = ST_IDLE;
               done_d = 1'b1;
            end
         end
         ST_BG: begin
            if (!bck_mode) begin
               // abandon mid-step, trims of this pass stay partial
               state_d = ST_IDLE;
            end else if (step_end) begin
               tick_d = 8'h00;
               trim_d = 1'b1;
               step_idx_d = step_idx_q + 1'b1;
               done_d = (step_idx_q == `ACR_VEC_LAST);
               // the step in flight always completes, hence the stop lag
               if (!cont) begin
                  state_d = ST_IDLE;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
            tick_d = 8'h00;
         end
      endcase
      if (fg_trigger_q) begin
         state_d = ST_FG;
         step_idx_d = {`ACR_VEC_IDX_W{1'b0}};
         tick_d = 8'h00;
         trim_d = 1'b0;
         done_d = 1'b0;
      end
   end

   // sequencer flops, status kept registered so outputs come from flops
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         state_q <= ST_IDLE;
         step_idx_q <= {`ACR_VEC_IDX_W{1'b0}};
         tick_q <= 8'h00;
         cal_running_out <= 1'b0;
         first_cal_done_out <= 1'b0;
      end else begin
         state_q <= state_d;
         step_idx_q <= step_idx_d;
         tick_q <= tick_d;
         cal_running_out <= (state_d != ST_IDLE);
         if (done_d) begin
            first_cal_done_out <= 1'b1;
         end
      end
   end

   acr_vector_store u_store (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .host_wr_in(vec_load),
      .host_idx_in(scan_ptr_q),
      .host_data_in(reg_wdata_in),
      .trim_in(trim_d),
      .trim_idx_in(step_idx_q),
      .rd_idx_in(scan_ptr_q),
      .rd_data_out(vec_rd_data)
   );

   // read data, one cycle after the strobe; unmapped offsets read zero
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         reg_rdata_out <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            case (reg_addr_in)
               `ACR_OFS_CAL_CFG0: begin
                  reg_rdata_out <= cfg0_q;
               end
               `ACR_OFS_BACK_CTRL: begin
                  reg_rdata_out <= back_ctrl_q;
               end
               `ACR_OFS_PAT_OVR: begin
                  reg_rdata_out <= {5'h00, test_pattern_enable_out, overrange_enable_out, 1'b0};
               end
               `ACR_OFS_VECTOR: begin
                  reg_rdata_out <= scan_en ? vec_rd_data : 8'h00;
               end
               `ACR_OFS_STATUS: begin
                  reg_rdata_out <= `ACR_STATUS_RSVD
                     | ({7'h00, !cal_running_out} << `ACR_STAT_STOPPED)
                     | ({7'h00, first_cal_done_out} << `ACR_STAT_FIRST_DONE);
               end
               `ACR_OFS_TIMING: begin
                  reg_rdata_out <= timing_q;
               end
               default: begin
                  reg_rdata_out <= 8'h00;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ### rtl/acr_defines.vh
// register offsets, field positions, reset values and timing counts for acr
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH

// register offsets
`define ACR_ADDR_W 9
`define ACR_OFS_CAL_CFG0 9'h050
`define ACR_OFS_BACK_CTRL 9'h057
`define ACR_OFS_PAT_OVR 9'h058
`define ACR_OFS_VECTOR 9'h05a
`define ACR_OFS_STATUS 9'h05b
`define ACR_OFS_TIMING 9'h066

// reset values
`define ACR_RST_CAL_CFG0 8'h06
`define ACR_RST_BACK_CTRL 8'h10
`define ACR_RST_PAT_OVR 8'h00
`define ACR_RST_TIMING 8'h02
`define ACR_STATUS_RSVD 8'h08

// field positions
`define ACR_CFG0_FG_TRIGGER 3
`define ACR_CFG0_SCAN_EN 4
`define ACR_BACK_MODE_SELECT 0
`define ACR_BACK_CONTINUE 1
`define ACR_PAT_OVERRANGE 1
`define ACR_PAT_TEST_PATTERN 2
`define ACR_STAT_FIRST_DONE 0
`define ACR_STAT_STOPPED 1
`define ACR_TIMING_AUTO 0

// calibration store and sequencer timing
`define ACR_VEC_COUNT 16
`define ACR_VEC_IDX_W 4
`define ACR_VEC_LAST 4'hf
`define ACR_STEP_CYCLES 8'h04
`define ACR_TIMING_CYCLES 8'h20

`endif

// ### rtl/acr_vector_store.v
// calibration value store: one byte per entry, host load has priority over trim update
`timescale 1ns/1ps
`default_nettype none
`include "acr_defines.vh"

module acr_vector_store (
   // clock and reset
   input wire core_clk_in,
   input wire reset_in,
   // host load port
   input wire host_wr_in,
   input wire [`ACR_VEC_IDX_W-1:0] host_idx_in,
   input wire [7:0] host_data_in,
   // sequencer trim port
   input wire trim_in,
   input wire [`ACR_VEC_IDX_W-1:0] trim_idx_in,
   // read port
   input wire [`ACR_VEC_IDX_W-1:0] rd_idx_in,
   output wire [7:0] rd_data_out
);

   wire [7:0] entry_w [0:`ACR_VEC_COUNT-1];

   genvar g;
   generate
      for (g = 0; g < `ACR_VEC_COUNT; g = g + 1) begin : g_entry
         localparam [31:0] ENTRY = g;
         reg [7:0] value_q;
         always @(posedge core_clk_in) begin
            if (reset_in) begin
               value_q <= 8'h00;
            end else if (host_wr_in && (host_idx_in == ENTRY[`ACR_VEC_IDX_W-1:0])) begin
               value_q <= host_data_in;
            end else if (trim_in && (trim_idx_in == ENTRY[`ACR_VEC_IDX_W-1:0])) begin
               value_q <= value_q + 8'h01;
            end
         end
         assign entry_w[g] = value_q;
      end
   endgenerate

   assign rd_data_out = entry_w[rd_idx_in];

endmodule

`default_nettype wire

// ### bench/acr_cal_regs_assertions.sv
// concurrent checks on the calibration register block ports
`timescale 1ns/1ps
`default_nettype none
module acr_cal_regs_checker (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // register port
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [8:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   // converter controls and status
   input wire logic test_pattern_enable_out,
   input wire logic overrange_enable_out,
   input wire logic cal_running_out,
   input wire logic first_cal_done_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   wire logic pat_wr = reg_wr_in && reg_addr_in == 9'h058;
   wire logic bk_wr = reg_wr_in && reg_addr_in == 9'h057;
   property p_rvalid; reg_rd_in |=> reg_rvalid_out; endproperty
   property p_no_rvalid; !reg_rd_in |=> !reg_rvalid_out; endproperty
   property p_rdata_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
   // enables follow the written bits on the very next edge
   property p_pat_load;
      pat_wr |=> test_pattern_enable_out == $past(reg_wdata_in[2])
         && overrange_enable_out == $past(reg_wdata_in[1]);
   endproperty
   property p_pat_hold;
      !pat_wr [*2] |=> $stable(test_pattern_enable_out) && $stable(overrange_enable_out);
   endproperty
   property p_stat_read;
      reg_rd_in && reg_addr_in == 9'h05b |=> reg_rdata_out[7:2] == 6'h02
         && reg_rdata_out[1] == !$past(cal_running_out)
         && reg_rdata_out[0] == $past(first_cal_done_out);
   endproperty
   property p_unmapped; reg_rd_in && reg_addr_in == 9'h059 |=> reg_rdata_out == 8'h00; endproperty
   property p_fg_start;
      reg_wr_in && reg_addr_in == 9'h050 && reg_wdata_in[3] |-> ##3 cal_running_out [*8];
   endproperty
   property p_first_sticky; first_cal_done_out |=> first_cal_done_out; endproperty
   property p_bg_start;
      bk_wr && reg_wdata_in[1:0] == 2'b11 && !cal_running_out |-> ##[1:3] cal_running_out;
   endproperty
   property p_mode_needed;
      bk_wr && reg_wdata_in[1:0] == 2'b10 && !cal_running_out |=> !cal_running_out [*4];
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   a_no_rvalid: assert property (p_no_rvalid) else $error("stray read valid");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   a_pat_load: assert property (p_pat_load) else $error("pattern outputs wrong");
   a_pat_hold: assert property (p_pat_hold) else $error("pattern outputs moved");
   a_stat_read: assert property (p_stat_read) else $error("status read wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_fg_start: assert property (p_fg_start) else $error("trigger did not run");
   a_first_sticky: assert property (p_first_sticky) else $error("first done fell");
   a_bg_start: assert property (p_bg_start) else $error("background did not start");
   a_mode_needed: assert property (p_mode_needed) else $error("ran without mode");
   c_pat: cover property (pat_wr);
   c_done: cover property ($fell(cal_running_out) && first_cal_done_out);
   c_vec: cover property (reg_rd_in && reg_addr_in == 9'h05a);
endmodule
bind acr_cal_regs acr_cal_regs_checker u_chk (.core_clk_in(core_clk_in), .reset_in(reset_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
   .test_pattern_enable_out(test_pattern_enable_out),
   .overrange_enable_out(overrange_enable_out), .cal_running_out(cal_running_out),
   .first_cal_done_out(first_cal_done_out));
`default_nettype wire

// ### bench/test_adc_calibration_control_regs.sv
// self-checking bench for the calibration register block
`timescale 1ns/1ps
`default_nettype none
module test_adc_calibration_control_regs;
   logic core_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [8:0] reg_addr_in = 9'h000;
   logic [7:0] reg_wdata_in = 8'h00;
   wire logic [7:0] reg_rdata_out;
   wire logic reg_rvalid_out, test_pattern_enable_out, overrange_enable_out;
   wire logic cal_running_out, first_cal_done_out;
   integer fails = 0;
   integer n_tests = 0;
   integer seed = 32'h4d2a86b3;
   integer i, t1, t2;
   logic [7:0] d;
   logic [7:0] vec [0:15];
   acr_cal_regs uut (.core_clk_in(core_clk_in), .reset_in(reset_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
      .test_pattern_enable_out(test_pattern_enable_out),
      .overrange_enable_out(overrange_enable_out), .cal_running_out(cal_running_out),
      .first_cal_done_out(first_cal_done_out));
   initial begin
      forever #25 core_clk_in = ~core_clk_in;
   end
   function automatic logic [7:0] pat_exp(input logic [7:0] v);
      return v & 8'h06;
   endfunction
   function automatic logic [7:0] stat_exp(input logic run, input logic done);
      return {6'h02, ~run, done};
   endfunction
   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wr(input logic [8:0] a, input logic [7:0] v);
      @(negedge core_clk_in);
      reg_addr_in = a;
      reg_wdata_in = v;
      reg_wr_in = 1'b1;
      @(negedge core_clk_in);
      reg_wr_in = 1'b0;
   endtask
   task rd(input logic [8:0] a, output logic [7:0] v);
      @(negedge core_clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge core_clk_in);
      reg_rd_in = 1'b0;
      chk("read valid", {7'h00, reg_rvalid_out}, 8'h01);
      v = reg_rdata_out;
   endtask
   task rdc(input logic [8:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk($sformatf("reg %h", a), v & m, e);
   endtask
   // waits out one calibration run; the count is bounded so a stuck sequencer cannot hang
   task run_len(output integer n);
      n = 0;
      repeat (4) @(negedge core_clk_in);
      chk("running", {7'h00, cal_running_out}, 8'h01);
      while (cal_running_out === 1'b1 && n < 500) begin
         @(negedge core_clk_in);
         n = n + 1;
      end
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #400000;
      fails = fails + 1;
      results;
   end
   initial begin
      repeat (5) @(negedge core_clk_in);
      reset_in = 1'b0;
      rdc(9'h050, 8'hff, 8'h06);
      rdc(9'h057, 8'hff, 8'h10);
      rdc(9'h058, 8'hff, 8'h00);
      rdc(9'h066, 8'hff, 8'h02);
      rdc(9'h05a, 8'hff, 8'h00);
      rdc(9'h05b, 8'hff, stat_exp(1'b0, 1'b0));
      rdc(9'h059, 8'hff, 8'h00);
      $display("test reset values done");
      for (i = 0; i < 10; i = i + 1) begin
         d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
         wr(9'h058, d);
         rdc(9'h058, 8'hff, pat_exp(d));
         chk("pattern pins", {6'h00, test_pattern_enable_out, overrange_enable_out}, d[2:1]);
      end
      $display("test pattern done");
      wr(9'h050, 8'h10);
      for (i = 0; i < 16; i = i + 1) begin
         vec[i] = 8'($random(seed));
         wr(9'h05a, vec[i]);
      end
      // a partial dump leaves the pointer mid-store, so the full dump below needs the restart
      for (i = 0; i < 3; i = i + 1) rdc(9'h05a, 8'hff, vec[i]);
      wr(9'h050, 8'h00);
      rdc(9'h05a, 8'hff, 8'h00);
      wr(9'h050, 8'h10);
      for (i = 0; i < 16; i = i + 1) rdc(9'h05a, 8'hff, vec[i]);
      $display("test scan done");
      wr(9'h050, 8'h08);
      run_len(t1);
      // sixteen steps of four cycles, less the edges run_len skips before counting
      chk("fg length", 8'(t1), 8'(16 * 4 - 3));
      rdc(9'h05b, 8'hff, stat_exp(1'b0, 1'b1));
      chk("first done pin", {7'h00, first_cal_done_out}, 8'h01);
      rdc(9'h050, 8'hff, 8'h00);
      wr(9'h050, 8'h10);
      for (i = 0; i < 16; i = i + 1) rdc(9'h05a, 8'hff, vec[i] + 8'h01);
      wr(9'h066, 8'h03);
      rdc(9'h066, 8'h01, 8'h01);
      wr(9'h050, 8'h08);
      run_len(t2);
      chk("timing extra", 8'(t2 - t1), 8'h20);
      $display("test foreground done");
      wr(9'h066, 8'h02);
      wr(9'h057, 8'h02);
      repeat (6) @(negedge core_clk_in);
      chk("mode off", {7'h00, cal_running_out}, 8'h00);
      wr(9'h057, 8'h03);
      repeat (2) @(negedge core_clk_in);
      chk("bg run", {7'h00, cal_running_out}, 8'h01);
      rdc(9'h05b, 8'h02, 8'h00);
      wr(9'h066, 8'h03);
      rdc(9'h066, 8'hff, 8'h02);
      wr(9'h057, 8'h11);
      d = 8'h00;
      for (i = 0; i < 10 && d[1] !== 1'b1; i = i + 1) rd(9'h05b, d);
      chk("stopped", d & 8'h02, 8'h02);
      rdc(9'h057, 8'hff, 8'h01);
      wr(9'h057, 8'h10);
      wr(9'h050, 8'h08);
      run_len(t1);
      chk("fg after bg", 8'(t1), 8'(16 * 4 - 3));
      rdc(9'h05b, 8'hff, stat_exp(1'b0, 1'b1));
      $display("test background done");
      results;
   end
endmodule
`default_nettype wire
